// File: rtl/prs_params.svh
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// Width of each configuration register bank.
`define PRS_CFG_W 8
// Reset value of the sticky and nonsticky configuration banks.
`define PRS_CFG_RST 8'h00
// Least cycles for which the application holds its resets after an exit pulse.
`define PRS_HOLD_HARD 2
`define PRS_HOLD_SOFT 1
// Width of the hold counter.
`define PRS_CNT_W 2

`endif

// File: rtl/prs_pkg.sv
`default_nettype none

package prs_pkg;

  typedef enum logic [1:0] {
    PRS_HARD,
    PRS_SOFT_X1X4,
    PRS_SOFT_X8
  } prs_variant_t;

  typedef enum logic [3:0] {
    PRS_LTSSM_DETECT,
    PRS_LTSSM_POLLING,
    PRS_LTSSM_CONFIG,
    PRS_LTSSM_L0,
    PRS_LTSSM_L0S,
    PRS_LTSSM_L1,
    PRS_LTSSM_L2_IDLE,
    PRS_LTSSM_RECOVERY,
    PRS_LTSSM_HOT_RESET,
    PRS_LTSSM_DISABLED
  } prs_ltssm_t;

  typedef enum logic {
    PRS_APP_IDLE,
    PRS_APP_HOLD
  } prs_app_state_t;

endpackage

`default_nettype wire

// File: rtl/prs_if.sv
`timescale 1ns/10ps
`default_nettype none

interface prs_if;
  logic por_n;
  logic dp_rst;
  logic cfg_rst;
  logic comb_rst_n;
  logic core_clr_n;
  logic all_clr;
  logic deep_sleep_exit_pulse_n;
  logic hot_reset_exit;
  logic link_down_exit_n;
  logic rx_pll_lock;

  modport core (
    input  por_n,
    input  dp_rst,
    input  cfg_rst,
    input  comb_rst_n,
    input  core_clr_n,
    input  all_clr,
    output deep_sleep_exit_pulse_n,
    output hot_reset_exit,
    output link_down_exit_n,
    output rx_pll_lock
  );

  modport app (
    output por_n,
    output dp_rst,
    output cfg_rst,
    output comb_rst_n,
    output core_clr_n,
    output all_clr,
    input  deep_sleep_exit_pulse_n,
    input  hot_reset_exit,
    input  link_down_exit_n,
    input  rx_pll_lock
  );
endinterface

`default_nettype wire

// File: rtl/prs_exit_pulse.sv
`timescale 1ns/10ps
`default_nettype none

module prs_exit_pulse #(
  parameter bit ACTIVE_LOW = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic arst,
  input  wire logic clr,
  input  wire logic fire,
  output logic      pulse
);

  logic pulse_d;
  logic pulse_q;

  // The pulse rests at its inactive level and takes the active one for the cycle after fire.
  assign pulse_d = clr ? ACTIVE_LOW : (fire ^ ACTIVE_LOW);

  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      pulse_q <= ACTIVE_LOW;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule

`default_nettype wire

// File: rtl/prs_core_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "prs_params.svh"


module prs_core_end
  import prs_pkg::*;
#(
  parameter prs_variant_t VARIANT = PRS_HARD
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  prs_if.core                        lnk,
  input  wire prs_ltssm_t            ltssm_state,
  input  wire logic                  link_control_fsm_up,
  input  wire logic                  pll_lock_raw,
  input  wire logic                  pipe_sim_mode,
  input  wire logic                  cfg_wr_en,
  input  wire logic                  cfg_wr_sticky,
  input  wire logic [`PRS_CFG_W-1:0] cfg_wr_data,
  output logic      [`PRS_CFG_W-1:0] sticky_cfg,
  output logic      [`PRS_CFG_W-1:0] nonsticky_cfg,
  output logic                       core_in_reset
);

  // Variants without split synchronous resets take the combined asynchronous one instead.
  localparam bit SPLIT_RESETS = (VARIANT != PRS_SOFT_X8);

  logic                  por_clr;
  logic                  dp_arst;
  logic                  sticky_clr;
  logic                  pma_clr;
  logic                  dp_clr;
  logic                  cfg_clr;
  logic                  l2_fire;
  logic                  hot_fire;
  logic                  dlup_fire;
  // Decoded conditions and next-state values that feed the clears, the exit detectors, the banks and the flags.
  logic                  comb_clr;
  logic                  split_dp_req;
  logic                  split_cfg_req;
  logic                  prev_in_l2;
  logic                  cur_in_detect;
  logic                  prev_in_hot;
  logic                  cur_in_hot;
  logic                  link_fell;
  logic                  sticky_wr;
  logic                  nonsticky_wr;
  logic                  lock_d;
  logic                  busy_d;
  logic [`PRS_CFG_W-1:0] sticky_d;
  logic [`PRS_CFG_W-1:0] nonsticky_d;

  prs_ltssm_t            ltssm_prev_q;
  logic                  dl_up_prev_q;
  logic                  lock_meta_q;
  logic                  lock_sync_q;
  logic                  lock_q;
  logic [`PRS_CFG_W-1:0] sticky_q;
  logic [`PRS_CFG_W-1:0] nonsticky_q;
  logic                  busy_q;

  // Only the eight-lane soft variant honours the combined reset; the others honour only the split pair.
  assign comb_clr      = ~SPLIT_RESETS & ~lnk.comb_rst_n;
  assign split_dp_req  = SPLIT_RESETS & lnk.dp_rst;
  assign split_cfg_req = SPLIT_RESETS & lnk.cfg_rst;

  assign por_clr    = rst | ~lnk.por_n;
  assign dp_arst    = por_clr | comb_clr;
  assign sticky_clr = ~lnk.core_clr_n | lnk.all_clr;
  assign pma_clr    = lnk.all_clr;
  assign dp_clr     = split_dp_req | sticky_clr;
  assign cfg_clr    = split_cfg_req | sticky_clr;

  // Exit events are transitions seen between the previous and current cycle.
  // A transition seen under a datapath clear is dropped, since the trackers restart then.
  assign prev_in_l2    = (ltssm_prev_q == PRS_LTSSM_L2_IDLE);
  assign cur_in_detect = (ltssm_state == PRS_LTSSM_DETECT);
  assign prev_in_hot   = (ltssm_prev_q == PRS_LTSSM_HOT_RESET);
  assign cur_in_hot    = (ltssm_state == PRS_LTSSM_HOT_RESET);
  assign link_fell     = dl_up_prev_q & ~link_control_fsm_up;

  assign l2_fire   = prev_in_l2 & cur_in_detect & ~dp_clr;
  assign hot_fire  = prev_in_hot & ~cur_in_hot & ~dp_clr;
  assign dlup_fire = link_fell & ~dp_clr;

  assign lock_d = pipe_sim_mode | lock_sync_q;

  // The datapath reset leaves the configuration banks alone; the nonsticky bank has its own clear.
  // A clear in the same cycle as a write wins, so no write survives a clear of its own bank.
  assign sticky_wr    = cfg_wr_en & cfg_wr_sticky;
  assign nonsticky_wr = cfg_wr_en & ~cfg_wr_sticky;
  assign sticky_d     = sticky_clr ? `PRS_CFG_RST : (sticky_wr ? cfg_wr_data : sticky_q);
  assign nonsticky_d  = cfg_clr ? `PRS_CFG_RST : (nonsticky_wr ? cfg_wr_data : nonsticky_q);

  assign busy_d = dp_clr | cfg_clr;

  // Datapath state trackers.
  always_ff @(posedge sys_clk or posedge dp_arst) begin
    if (dp_arst) begin
      ltssm_prev_q <= PRS_LTSSM_DETECT;
      dl_up_prev_q <= 1'b0;
    end else if (dp_clr) begin
      ltssm_prev_q <= PRS_LTSSM_DETECT;
      dl_up_prev_q <= 1'b0;
    end else begin
      ltssm_prev_q <= ltssm_state;
      dl_up_prev_q <= link_control_fsm_up;
    end
  end

  // Sticky bank survives every clear except power-on and the core clears.
  always_ff @(posedge sys_clk or posedge por_clr) begin
    if (por_clr) begin
      sticky_q <= `PRS_CFG_RST;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  always_ff @(posedge sys_clk or posedge dp_arst) begin
    if (dp_arst) begin
      nonsticky_q <= `PRS_CFG_RST;
      busy_q      <= 1'b1;
    end else begin
      nonsticky_q <= nonsticky_d;
      busy_q      <= busy_d;
    end
  end

  // Receiver PLL lock arrives from analog circuitry and is synchronised first.
  always_ff @(posedge sys_clk or posedge por_clr) begin
    if (por_clr) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
    end else if (pma_clr) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
    end else begin
      lock_meta_q <= pll_lock_raw;
      lock_sync_q <= lock_meta_q;
    end
  end

  // The lock flag has a flop of its own so that the output never comes from a synchroniser stage.
  always_ff @(posedge sys_clk or posedge por_clr) begin
    if (por_clr) begin
      lock_q <= 1'b0;
    end else if (pma_clr) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // Each exit indication is a registered pulse, held at rest while the datapath is cleared.
  prs_exit_pulse #(
    .ACTIVE_LOW (1'b1)
  ) u_deep_sleep_exit_pulse_n (
    .sys_clk (sys_clk),
    .arst    (dp_arst),
    .clr     (dp_clr),
    .fire    (l2_fire),
    .pulse   (lnk.deep_sleep_exit_pulse_n)
  );

  prs_exit_pulse #(
    .ACTIVE_LOW (1'b0)
  ) u_hot_exit (
    .sys_clk (sys_clk),
    .arst    (dp_arst),
    .clr     (dp_clr),
    .fire    (hot_fire),
    .pulse   (lnk.hot_reset_exit)
  );

  prs_exit_pulse #(
    .ACTIVE_LOW (1'b1)
  ) u_dlup_exit (
    .sys_clk (sys_clk),
    .arst    (dp_arst),
    .clr     (dp_clr),
    .fire    (dlup_fire),
    .pulse   (lnk.link_down_exit_n)
  );

  assign lnk.rx_pll_lock = lock_q;
  assign sticky_cfg      = sticky_q;
  assign nonsticky_cfg   = nonsticky_q;
  assign core_in_reset   = busy_q;

endmodule

`default_nettype wire

// File: rtl/prs_app_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "prs_params.svh"

module prs_app_end
  import prs_pkg::*;
#(
  parameter prs_variant_t VARIANT = PRS_HARD
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  prs_if.app        lnk,
  input  wire logic perst_n_pin,
  input  wire logic is_root_port,
  input  wire logic core_clr_req,
  input  wire logic all_clr_req,
  output logic      reset_busy,
  output logic      pll_locked
);

  localparam bit SPLIT_RESETS = (VARIANT != PRS_SOFT_X8);
  localparam logic [`PRS_CNT_W-1:0] HOLD_LOAD = (VARIANT == PRS_HARD) ?
    `PRS_CNT_W'(`PRS_HOLD_HARD - 1) : `PRS_CNT_W'(`PRS_HOLD_SOFT - 1);

  logic                  l2_ev;
  logic                  hot_ev;
  logic                  dl_ev;
  logic                  por_rise;
  logic                  want_dp;
  logic                  want_cfg;
  logic                  any_ev;
  prs_app_state_t        state_d;
  logic [`PRS_CNT_W-1:0] cnt_d;
  logic                  dp_d;
  logic                  cfg_d;

  prs_app_state_t        state_q;
  logic [`PRS_CNT_W-1:0] cnt_q;
  logic                  dp_q;
  logic                  cfg_q;
  logic                  comb_n_q;
  logic                  perst_meta_q;
  logic                  perst_sync_q;
  logic                  por_n_q;
  logic                  core_clr_n_q;
  logic                  all_clr_q;
  logic                  busy_q;
  logic                  lock_q;

  // Exit pulses come from the core on this same clock and need no synchroniser.
  assign l2_ev    = ~lnk.deep_sleep_exit_pulse_n;
  assign hot_ev   = lnk.hot_reset_exit;
  assign dl_ev    = ~lnk.link_down_exit_n;
  assign por_rise = ~por_n_q & perst_sync_q;
  assign want_dp  = l2_ev | hot_ev | dl_ev | por_rise;
  assign want_cfg = l2_ev | hot_ev | (dl_ev & ~is_root_port) | por_rise;
  assign any_ev   = want_dp | want_cfg;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    dp_d    = dp_q;
    cfg_d   = cfg_q;
    case (state_q)
      PRS_APP_IDLE: begin
        if (any_ev) begin
          state_d = PRS_APP_HOLD;
          cnt_d   = HOLD_LOAD;
          dp_d    = want_dp;
          cfg_d   = want_cfg;
        end
      end
      PRS_APP_HOLD: begin
        if (any_ev) begin
          cnt_d = HOLD_LOAD;
          dp_d  = dp_q | want_dp;
          cfg_d = cfg_q | want_cfg;
        end else if (cnt_q == '0) begin
          state_d = PRS_APP_IDLE;
          dp_d    = 1'b0;
          cfg_d   = 1'b0;
        end else begin
          cnt_d = cnt_q - `PRS_CNT_W'(1);
        end
      end
      default: begin
        state_d = PRS_APP_IDLE;
        dp_d    = 1'b0;
        cfg_d   = 1'b0;
      end
    endcase
  end

  // Every reset output is a flop on the fabric clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q  <= PRS_APP_IDLE;
      cnt_q    <= '0;
      dp_q     <= 1'b0;
      cfg_q    <= 1'b0;
      comb_n_q <= 1'b1;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      dp_q     <= SPLIT_RESETS & dp_d;
      cfg_q    <= SPLIT_RESETS & cfg_d;
      comb_n_q <= SPLIT_RESETS | ~(dp_d | cfg_d);
      busy_q   <= dp_d | cfg_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      perst_meta_q <= 1'b0;
      perst_sync_q <= 1'b0;
      por_n_q      <= 1'b0;
      core_clr_n_q <= 1'b1;
      all_clr_q    <= 1'b0;
      lock_q       <= 1'b0;
    end else begin
      perst_meta_q <= perst_n_pin;
      perst_sync_q <= perst_meta_q;
      por_n_q      <= perst_sync_q;
      core_clr_n_q <= ~core_clr_req;
      all_clr_q    <= all_clr_req;
      lock_q       <= lnk.rx_pll_lock;
    end
  end

  assign lnk.por_n      = por_n_q;
  assign lnk.dp_rst     = dp_q;
  assign lnk.cfg_rst    = cfg_q;
  assign lnk.comb_rst_n = comb_n_q;
  assign lnk.core_clr_n = core_clr_n_q;
  assign lnk.all_clr    = all_clr_q;
  assign reset_busy     = busy_q;
  assign pll_locked     = lock_q;

endmodule

`default_nettype wire

// File: verification/prs_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module prs_link_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por_n,
  input wire logic dp_rst,
  input wire logic cfg_rst,
  input wire logic comb_rst_n,
  input wire logic core_clr_n,
  input wire logic all_clr,
  input wire logic deep_sleep_exit_pulse_n,
  input wire logic hot_reset_exit,
  input wire logic link_down_exit_n,
  input wire logic rx_pll_lock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // The application answers a deep sleep or hot reset exit pulse with both resets on the next cycle.
  sequence both_clear_s;
    ##1 (dp_rst && cfg_rst);
  endsequence

  sequence hold_s;
    dp_rst [*2];
  endsequence

  // No exit indication is active.
  sequence quiet_s;
    deep_sleep_exit_pulse_n && !hot_reset_exit && link_down_exit_n;
  endsequence

  sleep_single_a: assert property ($fell(deep_sleep_exit_pulse_n) |=> deep_sleep_exit_pulse_n)
    else $error("deep sleep exit pulse wider than one cycle");
  hot_single_a: assert property (hot_reset_exit |=> !hot_reset_exit)
    else $error("hot reset exit pulse wider than one cycle");
  down_single_a: assert property (!link_down_exit_n |=> link_down_exit_n)
    else $error("link down exit pulse wider than one cycle");
  sleep_answer_a: assert property (!deep_sleep_exit_pulse_n |-> both_clear_s)
    else $error("no cold reset after deep sleep exit");
  hot_answer_a: assert property (hot_reset_exit |-> both_clear_s)
    else $error("no global reset after hot reset exit");
  down_answer_a: assert property (!link_down_exit_n |=> dp_rst)
    else $error("no datapath reset after link down exit");
  reset_hold_a: assert property ($rose(dp_rst) |-> hold_s)
    else $error("datapath reset held under two cycles");
  cfg_with_dp_a: assert property (cfg_rst |-> dp_rst)
    else $error("configuration reset without datapath reset");
  quiet_reset_a: assert property (dp_rst |=> (deep_sleep_exit_pulse_n && !hot_reset_exit && link_down_exit_n))
    else $error("exit pulse while datapath reset held");
  split_only_a: assert property (comb_rst_n)
    else $error("combined reset used in split reset variant");
  por_quiet_a: assert property (!por_n |-> quiet_s)
    else $error("exit pulse while power-on clear held");
  por_lock_a: assert property (!por_n |-> !rx_pll_lock)
    else $error("pll lock set while power-on clear held");
  core_quiet_a: assert property (!core_clr_n |=> quiet_s)
    else $error("exit pulse after core clear");
  lock_clear_a: assert property (all_clr |=> !rx_pll_lock)
    else $error("pll lock kept after combined clear");
endmodule

`default_nettype wire

// File: verification/pcie_core_reset_and_link_exit_signals_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "prs_params.svh"

module pcie_core_reset_and_link_exit_signals_bench
  import prs_pkg::*;
;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  prs_ltssm_t            ltssm_state = PRS_LTSSM_DETECT;
  logic                  link_control_fsm_up = 1'b0;
  logic                  pll_lock_raw = 1'b0;
  logic                  pipe_sim_mode = 1'b0;
  logic                  cfg_wr_en = 1'b0;
  logic                  cfg_wr_sticky = 1'b0;
  logic [`PRS_CFG_W-1:0] cfg_wr_data = 8'h00;
  logic                  perst_n_pin = 1'b1;
  logic                  is_root_port = 1'b0;
  logic                  core_clr_req = 1'b0;
  logic                  all_clr_req = 1'b0;
  logic [`PRS_CFG_W-1:0] sticky_cfg;
  logic [`PRS_CFG_W-1:0] nonsticky_cfg;
  logic                  core_in_reset;
  logic                  reset_busy;
  logic                  pll_locked;
  logic [7:0]            d_s;
  logic [7:0]            d_n;
  int                    mismatches = 0;
  int                    compares = 0;
  int                    seed = 32'h513A6993;

  prs_if lnk ();

  always #4 sys_clk = ~sys_clk;

  prs_core_end prs_core_end_inst (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .ltssm_state(ltssm_state),
    .link_control_fsm_up(link_control_fsm_up), .pll_lock_raw(pll_lock_raw), .pipe_sim_mode(pipe_sim_mode),
    .cfg_wr_en(cfg_wr_en), .cfg_wr_sticky(cfg_wr_sticky), .cfg_wr_data(cfg_wr_data), .sticky_cfg(sticky_cfg),
    .nonsticky_cfg(nonsticky_cfg), .core_in_reset(core_in_reset));
  prs_app_end prs_app_end_inst (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .perst_n_pin(perst_n_pin),
    .is_root_port(is_root_port), .core_clr_req(core_clr_req), .all_clr_req(all_clr_req),
    .reset_busy(reset_busy), .pll_locked(pll_locked));
  prs_link_monitor prs_link_monitor_inst (.sys_clk(sys_clk), .rst(rst), .por_n(lnk.por_n), .dp_rst(lnk.dp_rst),
    .cfg_rst(lnk.cfg_rst), .comb_rst_n(lnk.comb_rst_n), .core_clr_n(lnk.core_clr_n), .all_clr(lnk.all_clr),
    .deep_sleep_exit_pulse_n(lnk.deep_sleep_exit_pulse_n), .hot_reset_exit(lnk.hot_reset_exit),
    .link_down_exit_n(lnk.link_down_exit_n), .rx_pll_lock(lnk.rx_pll_lock));

  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  function automatic logic fired(input int k);
    case (k)
      0: return !lnk.deep_sleep_exit_pulse_n;
      1: return lnk.hot_reset_exit;
      default: return !lnk.link_down_exit_n;
    endcase
  endfunction

  // A root port keeps its configuration out of reset on link down.
  function automatic logic cfg_expected(input int k, input logic root);
    return !(k == 2 && root);
  endfunction

  task automatic exits(input int k);
    int   n;
    logic c;
    n = 0;
    c = cfg_expected(k, is_root_port);
    while (!fired(k) && n < 6) begin
      tick(1);
      n++;
    end
    if (n == 6) begin
      mismatches++;
      $display("Error at %0t: exit pulse missing", $time);
      results();
    end else begin
      tick(1);
      check(16'({fired(k), lnk.dp_rst, lnk.cfg_rst}), 16'({1'b0, 1'b1, c}));
      check(16'(reset_busy), 16'h0001);
      tick(1);
      check(16'({lnk.dp_rst, lnk.cfg_rst, core_in_reset}), 16'({1'b1, c, 1'b1}));
      tick(1);
      check(16'({lnk.dp_rst, lnk.cfg_rst, reset_busy}), 16'h0000);
    end
  endtask

  task automatic fire_exit(input int k);
    case (k)
      0: begin
        ltssm_state = PRS_LTSSM_L2_IDLE;
        tick(1);
        ltssm_state = PRS_LTSSM_DETECT;
      end
      1: begin
        ltssm_state = PRS_LTSSM_HOT_RESET;
        tick(1);
        ltssm_state = prs_ltssm_t'(4'($unsigned($random(seed)) % 8));
      end
      default: begin
        link_control_fsm_up = 1'b1;
        tick(2);
        link_control_fsm_up = 1'b0;
      end
    endcase
    exits(k);
  endtask

  task automatic cfg_write(input logic sticky, input logic [7:0] d);
    cfg_wr_en = 1'b1;
    cfg_wr_sticky = sticky;
    cfg_wr_data = d;
    tick(1);
    cfg_wr_en = 1'b0;
    tick(1);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    tick(10);
    check(16'(lnk.por_n), 16'h0001);
    pll_lock_raw = 1'b1;
    tick(5);
    check(16'({lnk.rx_pll_lock, pll_locked}), 16'h0003);
    pll_lock_raw = 1'b0;
    pipe_sim_mode = 1'b1;
    tick(5);
    check(16'({lnk.rx_pll_lock, pll_locked}), 16'h0003);
    pll_lock_raw = 1'b1;
    pipe_sim_mode = 1'b0;
    for (int i = 0; i < 12; i++) begin
      is_root_port = ((i / 3) % 2) == 1;
      d_s = 8'($random(seed));
      d_n = 8'($random(seed));
      cfg_write(1'b1, d_s);
      cfg_write(1'b0, d_n);
      check({sticky_cfg, nonsticky_cfg}, {d_s, d_n});
      fire_exit(i % 3);
      check({sticky_cfg, nonsticky_cfg}, {d_s, cfg_expected(i % 3, is_root_port) ? 8'h00 : d_n});
    end
    cfg_write(1'b1, 8'hA5);
    core_clr_req = 1'b1;
    tick(1);
    core_clr_req = 1'b0;
    tick(2);
    check(16'(sticky_cfg), 16'h0000);
    cfg_write(1'b1, 8'h5A);
    all_clr_req = 1'b1;
    tick(1);
    all_clr_req = 1'b0;
    tick(2);
    check(16'({lnk.rx_pll_lock, sticky_cfg}), 16'h0000);
    cfg_write(1'b1, 8'hC3);
    perst_n_pin = 1'b0;
    tick(4);
    check(16'({lnk.por_n, sticky_cfg}), 16'h0000);
    perst_n_pin = 1'b1;
    tick(10);
    check(16'({lnk.por_n, lnk.dp_rst}), 16'h0002);
    results();
  end
endmodule

`default_nettype wire
